// file: rtl/flash_sec_init.sv
// flash security state, backdoor unlock and reset-sequence gating
`timescale 1ns/1ns
`default_nettype none
`include "flash_sec_cfg.svh"
module flash_sec_init
  import flash_sec_pkg::*;
#(
  parameter logic [15:0] RST_SEQ_CYCLES   = `RST_SEQ_CYCLES,
  parameter logic [15:0] RST_STALL_CYCLES = `RST_STALL_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // nonvolatile configuration field as read during reset sequence
  input  wire nv_cfg_t     nv_cfg_in,
  input  wire key_set_t    nv_keys_in,
  input  wire logic        nv_read_error_in,
  input  wire logic        nv_double_fault_in,
  // erase-verify all blocks outcome from the array controller
  input  wire logic        all_erased_in,
  // cpu flash read port for program block 0
  input  wire logic        blk0_read_in,
  input  wire logic [15:0] blk0_data_in,
  output logic [15:0]      blk0_data_out,
  output logic             cpu_stall_out,
  output logic [1:0]       security_state_out,
  output logic             debug_enable_out,
  output logic             cmd_abort_out
);
  typedef enum logic [1:0] {SEQ_STALL, SEQ_BUSY, SEQ_DONE} seq_t;
  typedef enum logic [1:0] {CMD_IDLE, CMD_RUN} cmd_t;

  seq_t        seq_q;
  cmd_t        cmd_q;
  logic [15:0] seq_cnt_q;
  logic [15:0] cmd_cnt_q;
  nv_cfg_t     live_q;
  key_set_t    stored_keys_q;
  key_set_t    cand_q;
  logic [1:0]  sec_q;
  logic        key_lock_q;
  logic        ccf_q;
  logic        accerr_q;
  logic [1:0]  verr_q;
  logic [2:0]  idx_q;
  logic [7:0]  cmd_code_q;
  logic        debug_q;
  op_mode_t    mode_q;
  logic        cmd_running_q;
  logic        key_match;
  logic        rd_ready_q;
  logic        cmd_wr_ok;
  logic        launch;
  logic        allowed;

  key_compare key_compare_inst (
    .stored_in    (stored_keys_q),
    .presented_in (cand_q),
    .match_out    (key_match)
  );

  // waitrequest high through the initial stall; a read also waits one cycle so its registered data stands
  assign cpu_stall_out       = (seq_q == SEQ_STALL);
  assign avs_waitrequest_out = cpu_stall_out || (avs_read_in && !rd_ready_q);
  assign cmd_wr_ok           = avs_write_in && !cpu_stall_out && (seq_q == SEQ_DONE) && ccf_q;
  assign launch              = avs_write_in && !cpu_stall_out && (avs_address_in == `OFF_STATUS) &&
                               avs_byteenable_in[0] && avs_writedata_in[`ST_CCF_BIT] && ccf_q &&
                               (seq_q == SEQ_DONE);
  assign security_state_out  = sec_q;
  assign debug_enable_out    = debug_q;
  assign cmd_abort_out       = !resetn_in && cmd_running_q;

  // command availability from mode and security
  always_comb begin
    case (cmd_code_q)
      `CMD_VERIFY_KEY: allowed = !key_lock_q && (live_q.security[7:6] == `KEY_ENABLE_ON);
      `CMD_VERIFY_ALL: allowed = 1'b1;
      `CMD_ERASE_ALL:  allowed = (mode_q != MODE_NORMAL) || (sec_q == `SEC_UNSECURE);
      default:         allowed = (sec_q == `SEC_UNSECURE) || (mode_q == MODE_NORMAL);
    endcase
  end

  // reset sequence: stall, then busy, then done
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      seq_q     <= SEQ_STALL;
      seq_cnt_q <= 16'h0000;
    end else begin
      case (seq_q)
        SEQ_STALL: begin
          seq_cnt_q <= seq_cnt_q + 16'h0001;
          if (seq_cnt_q + 16'h0001 >= RST_STALL_CYCLES) seq_q <= SEQ_BUSY;
        end
        SEQ_BUSY: begin
          seq_cnt_q <= seq_cnt_q + 16'h0001;
          if (seq_cnt_q + 16'h0001 >= RST_SEQ_CYCLES) seq_q <= SEQ_DONE;
        end
        SEQ_DONE: seq_cnt_q <= seq_cnt_q;
        default:  seq_q <= SEQ_STALL;
      endcase
    end
  end

  // configuration load at end of stall; defaults on error
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      live_q        <= '{`DEF_SECURITY, `DEF_PROT, `DEF_PROT, `DEF_OPTION, `DEF_BLKCFG};
      stored_keys_q <= '0;
      verr_q        <= 2'h0;
    end else if (seq_q == SEQ_STALL && seq_cnt_q + 16'h0001 >= RST_STALL_CYCLES) begin
      if (nv_read_error_in || nv_double_fault_in) begin
        live_q        <= '{`DEF_SECURITY, `DEF_PROT, `DEF_PROT, `DEF_OPTION, `DEF_BLKCFG};
        stored_keys_q <= '0;
      end else begin
        live_q        <= nv_cfg_in;
        stored_keys_q <= nv_keys_in;
      end
      if (nv_double_fault_in) verr_q <= 2'h3;
    end else if (launch) begin
      verr_q <= 2'h0;
    end
  end

  // live security: loaded once per reset, only unlocks change it afterwards (stored byte never written)
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sec_q   <= `SEC_SECURED;
      debug_q <= 1'b0;
    end else if (seq_q == SEQ_STALL && seq_cnt_q + 16'h0001 >= RST_STALL_CYCLES) begin
      sec_q <= (nv_read_error_in || nv_double_fault_in) ? `SEC_SECURED : nv_cfg_in.security[1:0];
    end else if (cmd_q == CMD_RUN && cmd_cnt_q == `CMD_DONE_CYCLES) begin
      if (cmd_code_q == `CMD_VERIFY_KEY && key_match)
        sec_q <= `SEC_UNSECURE;
      if (cmd_code_q == `CMD_VERIFY_ALL && mode_q == MODE_SPECIAL_SINGLE && all_erased_in) begin
        sec_q   <= `SEC_UNSECURE;
        debug_q <= 1'b1;
      end
    end
  end

  // wrong key lockout survives until reset
  always_ff @(posedge clk_in) begin
    if (!resetn_in) key_lock_q <= 1'b0;
    else if (cmd_q == CMD_RUN && cmd_cnt_q == `CMD_DONE_CYCLES && cmd_code_q == `CMD_VERIFY_KEY && !key_match)
      key_lock_q <= 1'b1;
  end

  // command loading and execution
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cmd_q         <= CMD_IDLE;
      cmd_cnt_q     <= 16'h0000;
      ccf_q         <= 1'b0;
      accerr_q      <= 1'b0;
      idx_q         <= 3'h0;
      cmd_code_q    <= 8'h00;
      cand_q        <= '0;
      mode_q        <= MODE_NORMAL;
      cmd_running_q <= 1'b0;
    end else begin
      if (seq_q == SEQ_BUSY && seq_cnt_q + 16'h0001 >= RST_SEQ_CYCLES) ccf_q <= 1'b1;
      if (cmd_wr_ok && avs_address_in == `OFF_CMD_INDEX) idx_q <= avs_writedata_in[2:0];
      if (cmd_wr_ok && avs_address_in == `OFF_MODE) mode_q <= op_mode_t'(avs_writedata_in[1:0]);
      if (cmd_wr_ok && avs_address_in == `OFF_CMD_DATA) begin
        case (idx_q)
          3'h0: cmd_code_q <= avs_writedata_in[15:8];
          3'h1: cand_q.k0  <= avs_writedata_in[15:0];
          3'h2: cand_q.k1  <= avs_writedata_in[15:0];
          3'h3: cand_q.k2  <= avs_writedata_in[15:0];
          3'h4: cand_q.k3  <= avs_writedata_in[15:0];
          default: cand_q  <= cand_q;
        endcase
      end
      case (cmd_q)
        CMD_IDLE: begin
          if (launch) begin
            if (allowed) begin
              ccf_q         <= 1'b0;
              accerr_q      <= 1'b0;
              cmd_q         <= CMD_RUN;
              cmd_cnt_q     <= 16'h0000;
              cmd_running_q <= 1'b1;
            end else begin
              accerr_q <= 1'b1;
            end
          end
        end
        CMD_RUN: begin
          cmd_cnt_q <= cmd_cnt_q + 16'h0001;
          if (cmd_cnt_q == `CMD_DONE_CYCLES) begin
            ccf_q         <= 1'b1;
            cmd_q         <= CMD_IDLE;
            cmd_running_q <= 1'b0;
          end
        end
        default: cmd_q <= CMD_IDLE;
      endcase
    end
  end

  // block 0 reads blanked while key verification runs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) blk0_data_out <= 16'h0000;
    else if (blk0_read_in)
      blk0_data_out <= (cmd_q == CMD_RUN && cmd_code_q == `CMD_VERIFY_KEY) ? `KEY_ONES : blk0_data_in;
  end

  // read data is loaded one cycle ahead of the accepting edge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) rd_ready_q <= 1'b0;
    else rd_ready_q <= avs_read_in && !cpu_stall_out && !rd_ready_q;
  end

  // register read mux; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && !cpu_stall_out && !rd_ready_q) begin
      case (avs_address_in)
        `OFF_STATUS:    avs_readdata_out <= {24'h0, ccf_q, 1'b0, accerr_q, 3'h0, verr_q};
        `OFF_CMD_INDEX: avs_readdata_out <= {29'h0, idx_q};
        `OFF_CMD_DATA:  avs_readdata_out <= {24'h0, cmd_code_q};
        `OFF_SECURITY:  avs_readdata_out <= {24'h0, live_q.security[7:2], sec_q};
        `OFF_PROT:      avs_readdata_out <= {16'h0, live_q.dflash_prot, live_q.pflash_prot};
        `OFF_OPTION:    avs_readdata_out <= {16'h0, live_q.blk_cfg, live_q.option};
        `OFF_MODE:      avs_readdata_out <= {29'h0, debug_q, 2'(mode_q)};
        default:        avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  property p_stall_ccf;
    @(posedge clk_in) disable iff (!resetn_in) (seq_q != SEQ_DONE) |-> !ccf_q;
  endproperty
  a_stall_ccf: assert property (p_stall_ccf) else $error("command flag high during reset sequence");

  property p_lock_sticky;
    @(posedge clk_in) disable iff (!resetn_in) key_lock_q |=> key_lock_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("key lockout released without reset");

  property p_prot_stable;
    @(posedge clk_in) disable iff (!resetn_in) (seq_q == SEQ_DONE) |=> $stable(live_q.pflash_prot);
  endproperty
  a_prot_stable: assert property (p_prot_stable) else $error("protection changed after reset sequence");

  property p_blank_read;
    @(posedge clk_in) disable iff (!resetn_in)
      (blk0_read_in && cmd_q == CMD_RUN && cmd_code_q == `CMD_VERIFY_KEY) |=> blk0_data_out == `KEY_ONES;
  endproperty
  a_blank_read: assert property (p_blank_read) else $error("block 0 data visible during verification");

  property p_unlock;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_q == CMD_RUN && cmd_cnt_q == `CMD_DONE_CYCLES && cmd_code_q == `CMD_VERIFY_KEY && key_match)
      |=> sec_q == `SEC_UNSECURE;
  endproperty
  a_unlock: assert property (p_unlock) else $error("matching key did not unsecure");

  property p_no_cmd_write;
    @(posedge clk_in) disable iff (!resetn_in) (seq_q != SEQ_DONE) |=> $stable(idx_q);
  endproperty
  a_no_cmd_write: assert property (p_no_cmd_write) else $error("command index written during sequence");

  property p_dfault;
    @(posedge clk_in) disable iff (!resetn_in)
      (seq_q == SEQ_STALL && seq_cnt_q + 16'h0001 >= RST_STALL_CYCLES && nv_double_fault_in) |=> verr_q == 2'h3;
  endproperty
  a_dfault: assert property (p_dfault) else $error("double fault did not set both verify bits");

  property p_launch;
    @(posedge clk_in) disable iff (!resetn_in) (launch && allowed && cmd_q == CMD_IDLE) |=> !ccf_q ##5 ccf_q;
  endproperty
  a_launch: assert property (p_launch) else $error("command flag timing wrong after launch");

  property p_abort;
    @(posedge clk_in) (!resetn_in && cmd_running_q) |=> (cmd_q == CMD_IDLE) && !cmd_running_q;
  endproperty
  a_abort: assert property (p_abort) else $error("command survived a reset");

  property p_lock_refuse;
    @(posedge clk_in) disable iff (!resetn_in)
      (launch && cmd_q == CMD_IDLE && cmd_code_q == `CMD_VERIFY_KEY && key_lock_q) |=> cmd_q == CMD_IDLE && accerr_q;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("key verification accepted after lockout");

  property p_erase_unlock;
    @(posedge clk_in) disable iff (!resetn_in)
      (cmd_q == CMD_RUN && cmd_cnt_q == `CMD_DONE_CYCLES && cmd_code_q == `CMD_VERIFY_ALL &&
       mode_q == MODE_SPECIAL_SINGLE && all_erased_in) |=> sec_q == `SEC_UNSECURE && debug_q;
  endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("erased arrays did not unsecure");

  property p_err_default;
    @(posedge clk_in) disable iff (!resetn_in)
      (seq_q == SEQ_STALL && seq_cnt_q + 16'h0001 >= RST_STALL_CYCLES && (nv_read_error_in || nv_double_fault_in))
      |=> sec_q == `SEC_SECURED && live_q.pflash_prot == `DEF_PROT;
  endproperty
  a_err_default: assert property (p_err_default) else $error("load error did not fall back to defaults");
endmodule : flash_sec_init
`default_nettype wire

// file: rtl/flash_sec_cfg.svh
// constants for the flash security and reset-initialisation block
// Notes on behaviour
// - security register loads from the configuration security byte during reset.
// - a newly programmed security byte only matters after the next reset.
// - backdoor key is four stored 16-bit words compared with four presented words.
// - with keys enabled and all four matching, security field forced to 10.
// - stored keys of all zeros or all ones never unsecure.
// - block 0 reads return invalid data while key verification runs.
// - a wrong key locks out key verification until next reset.
// - verification never changes stored security byte or stored keys.
// - verification never changes program flash protection.
// - erase-verify all passing in special single chip mode unsecures and opens debug.
// - command acceptance depends on mode and security state.
// - reset sequence loads block config, both protections, option and security.
// - any reset sequence error falls back to fully protected secured defaults.
// - double-bit fault in reset sequence sets both verify error bits.
// - command-complete low during sequence; CPU stalled in its first part.
// - after stall, reads proceed but command writes dropped until sequence ends.
// - reset aborts any running command at once.
// - clearing command-complete launches; device sets it when done.
`ifndef FLASH_SEC_CFG_SVH
`define FLASH_SEC_CFG_SVH
`define SEC_BYTE_ADDR     23'h7fff0f
`define KEY_BASE_ADDR     23'h7fff00
`define KEY_LAST_ADDR     23'h7fff07
`define SEC_UNSECURE      2'h2
`define SEC_SECURED       2'h3
`define KEY_ENABLE_ON     2'h2
`define KEY_ZERO          16'h0000
`define KEY_ONES          16'hffff
`define DEF_SECURITY      8'hff
`define DEF_PROT          8'h00
`define DEF_OPTION        8'hff
`define DEF_BLKCFG        8'h00
`define RST_SEQ_CYCLES    16'h0040
`define RST_STALL_CYCLES  16'h0010
`define CMD_VERIFY_KEY    8'h0c
`define CMD_VERIFY_ALL    8'h01
`define CMD_ERASE_ALL     8'h08
`define CMD_PROGRAM_P     8'h06
`define CMD_DONE_CYCLES   16'h0004
// avalon offsets (byte addresses, one word each)
`define OFF_STATUS        6'h00
`define OFF_CMD_INDEX     6'h04
`define OFF_CMD_DATA      6'h08
`define OFF_SECURITY      6'h0c
`define OFF_PROT          6'h10
`define OFF_OPTION        6'h14
`define OFF_MODE          6'h18
`define ST_CCF_BIT        7
`define ST_ACCERR_BIT     5
`define ST_VERR1_BIT      1
`define ST_VERR0_BIT      0
`endif

// file: rtl/flash_sec_pkg.sv
// types for the flash security and reset-initialisation block
package flash_sec_pkg;
  typedef struct packed {
    logic [7:0] security;
    logic [7:0] pflash_prot;
    logic [7:0] dflash_prot;
    logic [7:0] option;
    logic [7:0] blk_cfg;
  } nv_cfg_t;
  typedef struct packed {
    logic [15:0] k3;
    logic [15:0] k2;
    logic [15:0] k1;
    logic [15:0] k0;
  } key_set_t;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SPECIAL_SINGLE,
    MODE_SPECIAL_EXPANDED
  } op_mode_t;
endpackage : flash_sec_pkg

// file: rtl/key_compare.sv
// backdoor key comparator with invalid key screening
`timescale 1ns/1ns
`default_nettype none
`include "flash_sec_cfg.svh"
module key_compare
  import flash_sec_pkg::*;
(
  input  wire key_set_t stored_in,
  input  wire key_set_t presented_in,
  output logic          match_out
);
  function automatic logic word_ok(input logic [15:0] s, input logic [15:0] p);
    word_ok = (s == p) && (s != `KEY_ZERO) && (s != `KEY_ONES);
  endfunction : word_ok

  assign match_out = word_ok(stored_in.k0, presented_in.k0) && word_ok(stored_in.k1, presented_in.k1) &&
                     word_ok(stored_in.k2, presented_in.k2) && word_ok(stored_in.k3, presented_in.k3);
endmodule : key_compare
`default_nettype wire

// file: verification/nv_field_model.sv
// configuration field and block 0 array model on the far side of the flash block
`timescale 1ns/1ns
`default_nettype none
module nv_field_model
  import flash_sec_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [1:0] security_state_in,
  input  wire logic       prog_in,
  input  wire logic       force_in,
  input  wire logic [7:0] prog_sec_in,
  input  wire key_set_t   prog_keys_in,
  input  wire logic       erase_in,
  input  wire logic [1:0] fault_in,
  output nv_cfg_t         nv_cfg_out,
  output key_set_t        nv_keys_out,
  output logic            read_error_out,
  output logic            double_fault_out,
  output logic            all_erased_out,
  output logic [15:0]     blk0_data_out
);
  logic [7:0]  sec_q = 8'h83;
  key_set_t    keys_q = 64'h4444_3333_2222_1111;
  logic        erased_q = 1'b0;
  logic [15:0] pat_q = 16'h0001;
  // array data changes every cycle so a stale word can never pass for valid data
  always @(posedge clk_in) begin
    pat_q <= {pat_q[14:0], pat_q[15] ^ pat_q[13]};
    if (erase_in) begin
      sec_q <= 8'hff;
      keys_q <= '1;
      erased_q <= 1'b1;
    end else if (force_in || (prog_in && security_state_in == 2'h2)) begin
      sec_q <= prog_sec_in;
      keys_q <= prog_keys_in;
      erased_q <= 1'b0;
    end
  end
  assign nv_cfg_out       = '{security: sec_q, pflash_prot: 8'h5c, dflash_prot: 8'h3a, option: 8'h96, blk_cfg: 8'h21};
  assign nv_keys_out      = keys_q;
  assign read_error_out   = fault_in[0];
  assign double_fault_out = fault_in[1];
  assign all_erased_out   = erased_q;
  assign blk0_data_out    = pat_q;
endmodule : nv_field_model
`default_nettype wire

// file: verification/flash_sec_init_test.sv
// register-level tests of the flash security and reset-initialisation block
`timescale 1ns/1ns
`default_nettype none
`include "flash_sec_cfg.svh"
module flash_sec_init_test;
  import flash_sec_pkg::*;
  localparam key_set_t KEYS = 64'h4444_3333_2222_1111;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [5:0]  avs_address_in = 6'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  nv_cfg_t     nv_cfg;
  key_set_t    nv_keys;
  logic        nv_err, nv_dbl, all_erased, cpu_stall_out, debug_enable_out, cmd_abort_out;
  logic        blk0_read_in = 1'b0;
  logic [15:0] blk0_data, blk0_data_out;
  logic [1:0]  security_state_out;
  logic        prog = 1'b0, force_ld = 1'b0, erase = 1'b0;
  logic [7:0]  prog_sec = 8'h83;
  key_set_t    prog_keys = KEYS;
  logic [1:0]  fault = 2'h0;
  logic [31:0] rd_val;
  int          n_mismatch = 0;
  int          check_count = 0;
  always #4 clk_in = ~clk_in;
  // short counts keep the run brief; stall ends well before the sequence does
  flash_sec_init #(.RST_SEQ_CYCLES(16'h0010), .RST_STALL_CYCLES(16'h0004)) flash_sec_init_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .nv_cfg_in(nv_cfg),
    .nv_keys_in(nv_keys), .nv_read_error_in(nv_err), .nv_double_fault_in(nv_dbl), .all_erased_in(all_erased),
    .blk0_read_in(blk0_read_in), .blk0_data_in(blk0_data), .blk0_data_out(blk0_data_out),
    .cpu_stall_out(cpu_stall_out), .security_state_out(security_state_out),
    .debug_enable_out(debug_enable_out), .cmd_abort_out(cmd_abort_out));
  nv_field_model nv_field_model_inst (
    .clk_in(clk_in), .security_state_in(security_state_out), .prog_in(prog), .force_in(force_ld),
    .prog_sec_in(prog_sec), .prog_keys_in(prog_keys), .erase_in(erase), .fault_in(fault), .nv_cfg_out(nv_cfg),
    .nv_keys_out(nv_keys), .read_error_out(nv_err), .double_fault_out(nv_dbl), .all_erased_out(all_erased),
    .blk0_data_out(blk0_data));
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until the rising edge that sees waitrequest low; data taken at that edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd_val = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask : rd
  task automatic wait_ccf;
    rd_val = 32'h0;
    for (int i = 0; i < 40 && rd_val[`ST_CCF_BIT] !== 1'b1; i++) rd(`OFF_STATUS);
    chk(32'(rd_val[`ST_CCF_BIT]), 32'h1);
  endtask : wait_ccf
  task automatic cmd(input logic [7:0] code, input key_set_t k);
    wr(`OFF_CMD_INDEX, 32'h0);
    wr(`OFF_CMD_DATA, {16'h0, code, 8'h00});
    for (int i = 1; i <= 4; i++) begin
      wr(`OFF_CMD_INDEX, 32'(i));
      wr(`OFF_CMD_DATA, {16'h0, k[16*(i-1) +: 16]});
    end
    wr(`OFF_STATUS, 32'h80);
  endtask : cmd
  task automatic do_reset;
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
  endtask : do_reset
  task automatic load(input logic [7:0] s, input key_set_t k, input logic unsecured_only);
    @(posedge clk_in);
    prog_sec <= s;
    prog_keys <= k;
    prog <= unsecured_only;
    force_ld <= !unsecured_only;
    @(posedge clk_in);
    prog <= 1'b0;
    force_ld <= 1'b0;
  endtask : load
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end
  initial begin
    do_reset();
    @(negedge clk_in);
    chk(32'(cpu_stall_out), 32'h1);
    rd(`OFF_STATUS);
    chk(32'(rd_val[`ST_CCF_BIT]), 32'h0);
    wr(`OFF_CMD_INDEX, 32'h5);
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_SECURED));
    rd(`OFF_CMD_INDEX);
    chk(rd_val, 32'h0);
    cmd(`CMD_VERIFY_KEY, KEYS);
    blk0_read_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(blk0_data_out), 32'hffff);
    @(posedge clk_in);
    blk0_read_in <= 1'b0;
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_UNSECURE));
    blk0_read_in <= 1'b1;
    @(posedge clk_in);
    rd_val = 32'(blk0_data);
    @(negedge clk_in);
    chk(32'(blk0_data_out), rd_val);
    @(posedge clk_in);
    blk0_read_in <= 1'b0;
    rd(`OFF_PROT);
    chk(32'(rd_val[7:0]), 32'h5c);
    do_reset();
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_SECURED));
    cmd(`CMD_VERIFY_KEY, KEYS ^ 64'h1);
    wait_ccf();
    cmd(`CMD_VERIFY_KEY, KEYS);
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_SECURED));
    chk(32'(rd_val[`ST_ACCERR_BIT]), 32'h1);
    do_reset();
    wait_ccf();
    cmd(`CMD_VERIFY_KEY, KEYS);
    wait_ccf();
    load(8'h03, KEYS, 1'b1);
    chk(32'(security_state_out), 32'(`SEC_UNSECURE));
    do_reset();
    wait_ccf();
    cmd(`CMD_VERIFY_KEY, KEYS);
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_SECURED));
    for (int j = 0; j < 2; j++) begin
      load(8'h83, j ? '1 : '0, 1'b0);
      do_reset();
      wait_ccf();
      cmd(`CMD_VERIFY_KEY, j ? '1 : '0);
      wait_ccf();
      chk(32'(security_state_out), 32'(`SEC_SECURED));
    end
    cmd(`CMD_ERASE_ALL, '0);
    wait_ccf();
    chk(32'(rd_val[`ST_ACCERR_BIT]), 32'h1);
    wr(`OFF_MODE, 32'h1);
    cmd(`CMD_ERASE_ALL, '0);
    wait_ccf();
    chk(32'(rd_val[`ST_ACCERR_BIT]), 32'h0);
    @(posedge clk_in);
    erase <= 1'b1;
    @(posedge clk_in);
    erase <= 1'b0;
    do_reset();
    wait_ccf();
    wr(`OFF_MODE, 32'h1);
    cmd(`CMD_VERIFY_ALL, '0);
    wait_ccf();
    chk(32'(security_state_out), 32'(`SEC_UNSECURE));
    chk(32'(debug_enable_out), 32'h1);
    cmd(`CMD_PROGRAM_P, '0);
    resetn_in <= 1'b0;
    @(negedge clk_in);
    chk(32'(cmd_abort_out), 32'h1);
    load(8'h82, KEYS, 1'b0);
    for (int f = 1; f <= 2; f++) begin
      fault <= 2'(f);
      do_reset();
      wait_ccf();
      chk(32'(security_state_out), 32'(`SEC_SECURED));
    end
    rd(`OFF_STATUS);
    chk(32'(rd_val[1:0]), 32'h3);
    conclude();
  end
endmodule : flash_sec_init_test
`default_nettype wire
